// *** logic/led_status_and_address_strap.sv ***
// Indicator outputs, management address strap capture and line speed select
`timescale 1ns/1ps

// Function
// - Duplex indicator shows full-duplex operation of the current link.
// - Collision indicator shows collisions, only while in half duplex.
// - Link indicator shows good link for both 10 and 100 Mb/s.
// - Transmit indicator on with transmit activity, off without.
// - Receive indicator on with receive activity, off without.
// - Speed indicator high at 100 Mb/s, low at 10 Mb/s.
// - Five strap pin levels captured at hardware reset as management address.
// - Every strapped address from 0 to 31 is accepted.
// - After reset release the strap pins become driven indicator outputs.
// - Transmit driver signalling follows the forced or negotiated speed.
// - Receive input path follows the forced or negotiated speed.
// - Isolate only when address zero strapped; register writes cannot select it.
module led_status_and_address_strap (
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  input  wire led_strap_pkg::link_status_s linkStatus,
  input  wire logic [4:0]                 strapPinIn,
  output logic      [4:0]                 strapPinOut,
  output logic      [4:0]                 strapPinOe,
  output logic                            speed_indicator,
  output logic      [4:0]                 mgmt_address_strap,
  output logic                            isolateMode,
  output led_strap_pkg::line_cfg_s         lineCfg
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // The port widths are fixed at the five shared pins; refuse package values that disagree
  if (led_strap_pkg::ADDR_W != 5) begin : g_addrWidthCheck
    $error("address width must match the five strap pins");
  end

  if (led_strap_pkg::LED_N != 5) begin : g_ledCountCheck
    $error("indicator count must match the five shared pins");
  end

  if (led_strap_pkg::BIT_RX >= led_strap_pkg::LED_N) begin : g_ledBitCheck
    $error("indicator bit positions exceed the shared pins");
  end

  if (led_strap_pkg::SETTLE_LAST < 2'h2) begin : g_settleCheck
    $error("settle count must cover both synchroniser stages");
  end

  // ==========================================================
  // State
  // ==========================================================
  typedef enum logic [1:0] {
    ST_RESET = 2'b01,
    ST_RUN   = 2'b10
  } strap_state_e;

  strap_state_e                strapState_r;
  strap_state_e                strapState_nxt;
  logic [1:0]                  settle_r;
  logic                        captureNow;
  logic                        running;
  logic [4:0]                  strapSync;
  logic [4:0]                  ledNxt;
  led_strap_pkg::link_status_s statusSync;

  // ==========================================================
  // Input synchronisation
  // ==========================================================
  // Strap pins are board levels; link status arrives from same-clock logic
  sync2 #(
    .WIDTH (5)
  ) u_strapSync (
    .mclk    (mclk),
    .resetn  (resetn),
    .asyncIn (strapPinIn),
    .syncOut (strapSync)
  );

  assign statusSync = linkStatus;

  // ==========================================================
  // Capture control
  // ==========================================================
  // The pins stay undriven for the settle cycles after release so the
  // synchroniser holds true pin levels when the capture is taken.
  assign captureNow = (strapState_r == ST_RESET) && (settle_r == led_strap_pkg::SETTLE_LAST);
  assign running    = (strapState_r == ST_RUN);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      settle_r <= 2'h0;
    end else if (strapState_r == ST_RESET) begin
      settle_r <= settle_r + led_strap_pkg::SETTLE_STEP;
    end
  end

  always_comb begin
    strapState_nxt = strapState_r;
    unique case (strapState_r)
      ST_RESET: begin
        if (captureNow) begin
          strapState_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        // Only a hardware reset leaves this state
        strapState_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      strapState_r <= ST_RESET;
    end else begin
      strapState_r <= strapState_nxt;
    end
  end

  // ==========================================================
  // Strap capture
  // ==========================================================
  // Taken once per hardware reset; later pin levels are indicator drive
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mgmt_address_strap <= led_strap_pkg::ADDR_RESET;
    end else if (captureNow) begin
      mgmt_address_strap <= strapSync;
    end
  end

  // Isolate follows the strapped value only; there is no write path to it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      isolateMode <= 1'b0;
    end else if (captureNow) begin
      isolateMode <= (strapSync == led_strap_pkg::ADDR_ISOLATE);
    end
  end

  // ==========================================================
  // Indicators
  // ==========================================================
  // Duplex is gated by link so a dead link never shows full duplex
  always_comb begin
    ledNxt                               = '0;
    ledNxt[led_strap_pkg::BIT_DUPLEX]    = statusSync.linkUp & statusSync.fullDuplex;
    ledNxt[led_strap_pkg::BIT_COLLISION] = statusSync.collision & ~statusSync.fullDuplex;
    ledNxt[led_strap_pkg::BIT_LINK]      = statusSync.linkUp;
    ledNxt[led_strap_pkg::BIT_TX]        = statusSync.txActive;
    ledNxt[led_strap_pkg::BIT_RX]        = statusSync.rxActive;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      strapPinOut <= '0;
    end else if (running) begin
      strapPinOut <= ledNxt;
    end
  end

  // Drive starts only after capture, so the strap resistors are never fought
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      strapPinOe <= '0;
    end else if (running) begin
      strapPinOe <= '1;
    end
  end

  // ==========================================================
  // Speed indicator
  // ==========================================================
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      speed_indicator <= 1'b0;
    end else begin
      speed_indicator <= statusSync.speed100;
    end
  end

  // ==========================================================
  // Line configuration
  // ==========================================================
  // Speed comes resolved from forced config or auto-negotiation upstream
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lineCfg <= '0;
    end else begin
      lineCfg.txMode100 <= statusSync.speed100;
      lineCfg.rxMode100 <= statusSync.speed100;
    end
  end

endmodule

// *** logic/led_strap_pkg.sv ***
// Package: constants and carrier structs for the indicator and strap block
package led_strap_pkg;

  localparam int          ADDR_W        = 5;
  localparam int          LED_N         = 5;
  localparam logic [4:0]  ADDR_ISOLATE  = 5'h00;
  localparam logic [4:0]  ADDR_RESET    = 5'h00;
  localparam int          BIT_DUPLEX    = 0;
  localparam int          BIT_COLLISION = 1;
  localparam int          BIT_LINK      = 2;
  localparam int          BIT_TX        = 3;
  localparam int          BIT_RX        = 4;
  // Settle count after reset release before the strap levels are taken
  localparam logic [1:0]  SETTLE_LAST   = 2'h2;
  localparam logic [1:0]  SETTLE_STEP   = 2'h1;

  // Resolved link state from auto-negotiation and the data path
  typedef struct packed {
    logic linkUp;
    logic speed100;
    logic fullDuplex;
    logic txActive;
    logic rxActive;
    logic collision;
  } link_status_s;

  // Line driver and receiver configuration
  typedef struct packed {
    logic txMode100;
    logic rxMode100;
  } line_cfg_s;

endpackage

// *** logic/sync2.sv ***
// Two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  initial begin
    if (WIDTH < 1) $error("sync2: WIDTH must be at least 1");
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stage1_r <= '0;
      syncOut  <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule

// *** testbench/led_strap_checker.sv ***
// Checker for indicator, speed and strap timing
`timescale 1ns/1ps
module led_strap_checker (
  input wire logic                        mclk,
  input wire logic                        resetn,
  input wire led_strap_pkg::link_status_s linkStatus,
  input wire logic [4:0]                  strapPinOut,
  input wire logic [4:0]                  strapPinOe,
  input wire logic                        speed_indicator,
  input wire logic [4:0]                  mgmt_address_strap,
  input wire logic                        isolateMode,
  input wire led_strap_pkg::line_cfg_s    lineCfg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  led_strap_pkg::link_status_s s;
  logic                        runR;
  logic                        run;
  assign s = linkStatus;
  assign run = runR && strapPinOe == 5'h1F;
  // Skip the first driven cycle, whose status may predate release
  always_ff @(posedge mclk) runR <= resetn && strapPinOe == 5'h1F;
  duplex_led_a: assert property (run |-> strapPinOut[0] == $past(s.fullDuplex && s.linkUp)) else $error("duplex");
  collision_led_a: assert property (run |-> strapPinOut[1] == $past(s.collision && !s.fullDuplex)) else $error("col");
  link_led_a: assert property (run |-> strapPinOut[2] == $past(s.linkUp)) else $error("link");
  tx_led_a: assert property (run |-> strapPinOut[3] == $past(s.txActive)) else $error("tx");
  rx_led_a: assert property (run |-> strapPinOut[4] == $past(s.rxActive)) else $error("rx");
  speed_led_a: assert property (run |-> speed_indicator == $past(s.speed100)) else $error("speed");
  line_cfg_a: assert property (run |-> lineCfg == {2{$past(s.speed100)}}) else $error("line");
  addr_hold_a: assert property (run |-> $stable(mgmt_address_strap)) else $error("addr");
  isolate_addr_a: assert property (run |-> isolateMode == (mgmt_address_strap == 5'h00)) else $error("iso");
  pin_release_a: assert property ($rose(resetn) |-> strapPinOe == 5'h00 ##[2:5] strapPinOe == 5'h1F) else $error("oe");
  cover property (run && s.collision && !s.fullDuplex);
  cover property (run && isolateMode);
  cover property ($rose(strapPinOe[0]));
endmodule
bind led_status_and_address_strap led_strap_checker chk (.*);

// *** testbench/strap_board.sv ***
// Board model: indicator loads and strap resistors on the shared pins
`timescale 1ns/1ps
module strap_board (
  input  wire logic [4:0] strapPinOut,
  input  wire logic [4:0] strapPinOe,
  input  wire logic [4:0] strapValue,
  output logic      [4:0] strapPinIn
);
  // No on-chip pulls, so the resistor sets the level only while undriven
  assign strapPinIn = (strapPinOe & strapPinOut) | (~strapPinOe & strapValue);
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench: strap capture and indicator scenarios
`timescale 1ns/1ps
module tb_top;
  logic                        mclk = 1'b0;
  logic                        resetn = 1'b0;
  led_strap_pkg::link_status_s linkStatus = '0;
  logic [4:0]                  strapValue = 5'h00;
  logic [4:0]                  strapPinIn, strapPinOut, strapPinOe, mgmt_address_strap;
  logic                        speed_indicator, isolateMode;
  led_strap_pkg::line_cfg_s    lineCfg;
  int                          mismatches = 0;
  int                          num_checks = 0;
  initial forever #5 mclk = ~mclk;
  strap_board board (.*);
  led_status_and_address_strap dut (.*);
  task step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(string what, logic [4:0] exp, logic [4:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task strap_test(logic [4:0] a);
    int n;
    strapValue = a;
    resetn = 1'b0;
    step(4);
    resetn = 1'b1;
    n = 0;
    while (strapPinOe !== 5'h1F) begin
      step(1);
      n++;
      if (n > 20) begin
        chk("oe wait", 5'h1F, strapPinOe);
        conclude();
      end
    end
    chk("address", a, mgmt_address_strap);
    chk("isolate", {4'h0, a == 5'h00}, {4'h0, isolateMode});
    $display("strap test %h done", a);
  endtask
  task status_test(logic [5:0] st, logic [4:0] leds, logic spd);
    linkStatus = st;
    step(3);
    chk("leds", leds, strapPinIn);
    chk("speed", {4'h0, spd}, {4'h0, speed_indicator});
    chk("line", {3'h0, spd, spd}, {3'h0, lineCfg});
    $display("status test %h done", st);
  endtask
  initial begin
    strap_test(5'h00);
    strap_test(5'h1F);
    strap_test(5'h0A);
    strap_test(5'h15);
    status_test(6'h3E, 5'h1D, 1'b1);
    status_test(6'h21, 5'h06, 1'b0);
    status_test(6'h39, 5'h05, 1'b1);
    status_test(6'h02, 5'h10, 1'b0);
    status_test(6'h2C, 5'h0D, 1'b0);
    conclude();
  end
endmodule
